// >>> selector_pkg.sv
// Shared constants and types for the position selector switch
package selector_pkg;
  localparam int ClkHz = 100_000_000;
  localparam int TickMs = 10;
  localparam int TickCycles = ClkHz / 1000 * TickMs;
  localparam int TickCntW = 20;
  localparam int FaultMs = 3000;
  localparam logic [9:0] FaultTicks = 10'(FaultMs / TickMs);
  localparam int TenthMs = 100;
  localparam logic [3:0] TicksPerTenth = 4'(TenthMs / TickMs);
  localparam logic [9:0] TimeoutMinTenths = 10'h01e;
  localparam logic [9:0] TimeoutMaxTenths = 10'h258;
  localparam logic [2:0] PosMin = 3'h1;
  localparam logic [2:0] PosNone = 3'h0;
  localparam logic [2:0] CodeRest = 3'h0;
  localparam logic [2:0] RangeMin = 3'h1;
  localparam logic [2:0] RangeMax = 3'h7;
  localparam logic [13:0] TimerZero = 14'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STEP = 2'b01,
    ST_CODE = 2'b10,
    ST_INIT = 2'b11
  } sel_state_t;

  typedef struct packed {
    logic [2:0] fullRange;
    logic [9:0] timeoutTenths;
    logic stepAckMode;
    logic codedAckMode;
    logic powerupFollow;
  } sel_cfg_t;

  typedef struct packed {
    logic [6:0] posOneHot;
    logic [2:0] posCode;
    logic rangeFault;
    logic incrementConfirmTimeoutFlag;
    logic codedConfirmTimeoutFlag;
    logic powerupPositionFault;
  } sel_out_t;
endpackage

// >>> position_selector_switch.sv
// Position selector switch: stepping and coded selection with timed apply and faults
// Operation
// - Increment rising edge advances, wraps to one
// - Coded word accepted only within range
// - Out-of-range word raises range fault 3s
// - Timeout mode applies after increment inactivity
// - Increment edge restarts timeout timer
// - Confirm mode: input activity restarts timer
// - Increment confirm edge applies before timeout
// - Missing increment confirm discards, flags 3s
// - Coded word is unsigned binary 1..7
// - All-zero coded word selects nothing, raises no range fault
// - Coded timeout mode applies after last change
// - Missing coded confirm rejects, flags 3s
// - Paths lock each other out while busy
// - Separate confirm inputs per path
// - Stored position restored or coded followed
// - Follow mode takes word; bad gives zero
// - Top position configurable one to seven
// - Timeout configurable 3.0 to 60.0 s
`timescale 1ns/1ns
module position_selector_switch (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire selector_pkg::sel_cfg_t cfg,
  input wire logic increment,
  input wire logic increment_confirm,
  input wire logic coded_select_bit0,
  input wire logic coded_select_bit1,
  input wire logic coded_select_bit2,
  input wire logic coded_confirm,
  input wire logic [2:0] storedPos,
  output selector_pkg::sel_out_t status,
  output logic storeWrite,
  output logic [2:0] storeData
);
  import selector_pkg::*;

  // Two-stage synchronisers for all asynchronous control inputs
  localparam int NIn = 6;
  logic [NIn-1:0] rawIn;
  logic [NIn-1:0] meta_r;
  logic [NIn-1:0] sync_r;
  logic [NIn-1:0] prev_r;
  assign rawIn = {coded_confirm, coded_select_bit2, coded_select_bit1,
                  coded_select_bit0, increment_confirm, increment};
  // Runs through reset so power-up follow mode sees the live word and no false edge follows
  always_ff @(posedge sys_clk) begin
    meta_r <= rawIn;
    sync_r <= meta_r;
    prev_r <= sync_r;
  end

  logic incRise, incAckRise, codeAckRise, codeChange;
  logic [2:0] codeWord;
  assign incRise = sync_r[0] & ~prev_r[0];
  assign incAckRise = sync_r[1] & ~prev_r[1];
  assign codeAckRise = sync_r[5] & ~prev_r[5];
  assign codeWord = sync_r[4:2];
  assign codeChange = sync_r[4:2] != prev_r[4:2];

  // Fixed 10 ms tick
  logic [TickCntW-1:0] tickCnt_r, tickCnt_nxt;
  logic tick;
  assign tick = tickCnt_r == TickCntW'(TickCycles - 1);
  always_comb begin
    tickCnt_nxt = tick ? '0 : tickCnt_r + 1'b1;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) tickCnt_r <= '0;
    else tickCnt_r <= tickCnt_nxt;
  end

  // Timeout limit, clamped to the allowed range
  logic [9:0] tenths;
  logic [13:0] limitTicks;
  logic [2:0] topPos;
  always_comb begin
    tenths = cfg.timeoutTenths;
    if (tenths < TimeoutMinTenths) tenths = TimeoutMinTenths;
    if (tenths > TimeoutMaxTenths) tenths = TimeoutMaxTenths;
    limitTicks = 14'(tenths) * 14'(TicksPerTenth);
    topPos = (cfg.fullRange < RangeMin) ? RangeMin : cfg.fullRange;
  end

  sel_state_t state_r, state_nxt;
  logic [2:0] pos_r, pos_nxt, pre_r, pre_nxt;
  logic [13:0] tmr_r, tmr_nxt;
  logic [9:0] rngCnt_r, rngCnt_nxt, stpCnt_r, stpCnt_nxt, bitCnt_r, bitCnt_nxt;
  logic pwrFault_r, pwrFault_nxt, wr_r, wr_nxt;
  logic codeValid, expired;

  assign codeValid = (codeWord >= RangeMin) && (codeWord <= topPos);
  assign expired = tick && (tmr_r + 1'b1 >= limitTicks);

  always_comb begin
    state_nxt = state_r;
    pos_nxt = pos_r;
    pre_nxt = pre_r;
    tmr_nxt = tmr_r;
    rngCnt_nxt = (rngCnt_r != '0 && tick) ? rngCnt_r - 1'b1 : rngCnt_r;
    stpCnt_nxt = (stpCnt_r != '0 && tick) ? stpCnt_r - 1'b1 : stpCnt_r;
    bitCnt_nxt = (bitCnt_r != '0 && tick) ? bitCnt_r - 1'b1 : bitCnt_r;
    pwrFault_nxt = pwrFault_r;
    wr_nxt = 1'b0;
    // Out-of-range nonzero word raises fault in any state but init and the step sequence
    if (codeChange && codeWord != CodeRest && !codeValid && state_r != ST_STEP &&
        state_r != ST_INIT)
      rngCnt_nxt = FaultTicks;
    case (state_r)
      ST_INIT: begin
        if (cfg.powerupFollow) begin
          if (codeValid) pos_nxt = codeWord;
          else begin
            pos_nxt = PosNone;
            pwrFault_nxt = 1'b1;
          end
        end else if (storedPos > topPos) begin
          pos_nxt = PosNone;
          pwrFault_nxt = 1'b1;
        end else begin
          pos_nxt = storedPos;
        end
        wr_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        tmr_nxt = TimerZero;
        if (incRise) begin
          pre_nxt = (pos_r >= topPos) ? PosMin : pos_r + 1'b1;
          state_nxt = ST_STEP;
        end else if (codeChange && codeValid) begin
          pre_nxt = codeWord;
          state_nxt = ST_CODE;
        end
      end
      ST_STEP: begin
        if (tick) tmr_nxt = tmr_r + 1'b1;
        if (incRise) begin
          pre_nxt = (pre_r >= topPos) ? PosMin : pre_r + 1'b1;
          tmr_nxt = TimerZero;
        end else if (cfg.stepAckMode && incAckRise) begin
          pos_nxt = pre_r;
          wr_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end else if (expired) begin
          if (cfg.stepAckMode) stpCnt_nxt = FaultTicks;
          else begin
            pos_nxt = pre_r;
            wr_nxt = 1'b1;
          end
          state_nxt = ST_IDLE;
        end
      end
      ST_CODE: begin
        if (tick) tmr_nxt = tmr_r + 1'b1;
        if (codeChange) begin
          tmr_nxt = TimerZero;
          if (codeValid) pre_nxt = codeWord;
        end else if (cfg.codedAckMode && codeAckRise) begin
          pos_nxt = pre_r;
          wr_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end else if (expired) begin
          if (cfg.codedAckMode) bitCnt_nxt = FaultTicks;
          else begin
            pos_nxt = pre_r;
            wr_nxt = 1'b1;
          end
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_INIT;
      pos_r <= PosNone;
      pre_r <= PosNone;
      tmr_r <= TimerZero;
      rngCnt_r <= '0;
      stpCnt_r <= '0;
      bitCnt_r <= '0;
      pwrFault_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pos_r <= pos_nxt;
      pre_r <= pre_nxt;
      tmr_r <= tmr_nxt;
      rngCnt_r <= rngCnt_nxt;
      stpCnt_r <= stpCnt_nxt;
      bitCnt_r <= bitCnt_nxt;
      pwrFault_r <= pwrFault_nxt;
      wr_r <= wr_nxt;
    end
  end

  // Registered outputs
  sel_out_t out_nxt;
  logic [6:0] hot;
  always_comb begin
    out_nxt.posOneHot = hot;
    out_nxt.posCode = pos_nxt;
    out_nxt.rangeFault = rngCnt_nxt != '0;
    out_nxt.incrementConfirmTimeoutFlag = stpCnt_nxt != '0;
    out_nxt.codedConfirmTimeoutFlag = bitCnt_nxt != '0;
    out_nxt.powerupPositionFault = pwrFault_nxt;
  end
  genvar gi;
  for (gi = 0; gi < 7; gi++) begin : g_hot
    assign hot[gi] = pos_nxt == 3'(gi + 1);
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status <= '0;
      storeWrite <= 1'b0;
      storeData <= PosNone;
    end else begin
      status <= out_nxt;
      storeWrite <= wr_nxt;
      storeData <= pos_nxt;
    end
  end
endmodule

// >>> position_selector_switch_chk.sv
// Assertion checker for the position selector switch
`timescale 1ns/1ns
module position_selector_switch_chk
  import selector_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire selector_pkg::sel_cfg_t cfg,
  input wire selector_pkg::sel_out_t status,
  input wire logic storeWrite,
  input wire logic [2:0] storeData
);
  logic [2:0] top;
  assign top = (cfg.fullRange == 3'h0) ? 3'h1 : cfg.fullRange;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_onehot_code: assert property (status.posOneHot == ((status.posCode == 3'h0) ? 7'h00 :
    7'h01 << (status.posCode - 3'h1))) else $error("one-hot and code disagree");
  a_store_on_move: assert property (!$stable(status.posCode) |-> storeWrite)
    else $error("position moved without store");
  a_store_data: assert property (storeWrite |-> storeData == status.posCode)
    else $error("stored value differs from position");
  a_pos_in_range: assert property (status.posCode <= top)
    else $error("position above top");
  a_range_hold: assert property ($rose(status.rangeFault) |-> status.rangeFault [*8])
    else $error("range fault too short");
  a_range_keeps_pos: assert property ($rose(status.rangeFault) |-> $stable(status.posCode))
    else $error("range fault moved position");
  a_pwr_sticky: assert property (status.powerupPositionFault |=> status.powerupPositionFault)
    else $error("power-up fault dropped");
  a_pwr_zero: assert property ($rose(status.powerupPositionFault) |-> status.posCode == 3'h0)
    else $error("power-up fault with nonzero position");
  a_step_alarm_keeps: assert property ($rose(status.incrementConfirmTimeoutFlag) |-> $stable(status.posCode))
    else $error("step alarm moved position");
  a_code_alarm_keeps: assert property ($rose(status.codedConfirmTimeoutFlag) |-> $stable(status.posCode))
    else $error("coded alarm moved position");
endmodule

bind position_selector_switch position_selector_switch_chk chk (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .cfg(cfg), .status(status), .storeWrite(storeWrite), .storeData(storeData));

// >>> selector_operands.sv
// Far-side logic operands that drive the selector inputs
`timescale 1ns/1ns
module selector_operands (
  input wire logic sys_clk,
  output logic [2:0] pulses,
  output logic [2:0] code
);
  initial begin
    pulses = 3'h0;
    code = 3'h0;
  end
  // One pulse on the chosen operand; the bench gives one increment between resets only
  task automatic pulse(input int k);
    @(negedge sys_clk);
    pulses[k] = 1'b1;
    repeat (5) @(negedge sys_clk);
    pulses[k] = 1'b0;
    repeat (10) @(negedge sys_clk);
  endtask
  task automatic setCode(input logic [2:0] v);
    code = v;
  endtask
endmodule

// >>> position_selector_switch_tb.sv
// Randomised self-checking bench for the position selector switch
`timescale 1ns/1ns
module position_selector_switch_tb;
  import selector_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  sel_cfg_t cfg = '0;
  sel_out_t status;
  logic storeWrite;
  logic [2:0] storeData, code, pulses, top, src, pos;
  logic [2:0] storedPos = 3'h0;
  int n_fail = 0;
  int checked = 0;
  position_selector_switch uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg(cfg),
    .increment(pulses[0]), .increment_confirm(pulses[1]), .coded_select_bit0(code[0]),
    .coded_select_bit1(code[1]), .coded_select_bit2(code[2]), .coded_confirm(pulses[2]),
    .storedPos(storedPos), .status(status), .storeWrite(storeWrite), .storeData(storeData));
  selector_operands drv (.sys_clk(sys_clk), .pulses(pulses), .code(code));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [2:0] expPos(input logic [2:0] s, input logic [2:0] t);
    return (s == 3'h0 || s > t) ? 3'h0 : s;
  endfunction
  function automatic logic [6:0] expHot(input logic [2:0] p);
    return (p == 3'h0) ? 7'h00 : 7'h01 << (p - 3'h1);
  endfunction
  task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h63a8));
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      sys_rst = 1'b1;
      top = 3'($urandom_range(7, 1));
      cfg = '{top, 10'h032, 1'b1, 1'b1, 1'($urandom)};
      storedPos = 3'($urandom);
      drv.setCode(3'(i));
      repeat (3) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      src = cfg.powerupFollow ? 3'(i) : storedPos;
      pos = expPos(src, top);
      check("pos", 7'(status.posCode), 7'(pos));
      check("pwrFault", 7'(status.powerupPositionFault),
        7'(cfg.powerupFollow ? pos == 3'h0 : src > top));
      drv.pulse(0);
      drv.setCode(3'(i + 2));
      drv.pulse(1);
      pos = (pos >= top) ? 3'h1 : pos + 3'h1;
      check("step", 7'(status.posCode), 7'(pos));
      check("lockRange", 7'(status.rangeFault), 7'h00);
      check("oneHot", status.posOneHot, expHot(pos));
      src = 3'(i + 1);
      drv.setCode(src);
      repeat (10) @(negedge sys_clk);
      check("rangeFault", 7'(status.rangeFault), 7'(src > top));
      drv.pulse(1);
      check("otherAck", 7'(status.posCode), 7'(pos));
      drv.pulse(2);
      pos = expPos(src, top) == 3'h0 ? pos : src;
      check("coded", 7'(status.posCode), 7'(pos));
      check("stored", 7'(storeData), 7'(pos));
      check("stepAlarm", 7'(status.incrementConfirmTimeoutFlag), 7'h00);
      check("codeAlarm", 7'(status.codedConfirmTimeoutFlag), 7'h00);
    end
    summarize();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end
endmodule
